// ==== rtl/tsr_pkg.sv ====
// Package for the sensor two-wire register access block
package tsr_pkg;
    // ----------------------------------------
    // Register pointer values
    // ----------------------------------------
    localparam logic [1:0] PTR_TEMP = 2'h0; // Measured temperature, read only
    localparam logic [1:0] PTR_CONFIG = 2'h1; // Configuration, 8 bits
    localparam logic [1:0] PTR_HYST = 2'h2; // hysteresis_limit
    localparam logic [1:0] PTR_OVER = 2'h3; // Overtemperature limit
    localparam logic [1:0] PTR_RESET = 2'h0; // Pointer after reset
    // ----------------------------------------
    // Reset values and field layout
    // ----------------------------------------
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [15:0] HYST_RESET = 16'h4B00;
    localparam logic [15:0] OVER_RESET = 16'h5000;
    localparam logic [15:0] LIMIT_MASK = 16'hFF80; // Low seven bits read zero
    localparam int CFG_INT_MODE_BIT = 1; // Interrupt mode select
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int TIMEOUT_MS = 250;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * 1000 / (1000 / CLK_MHZ) / 1000 * 1000;
    localparam int TIMEOUT_W = 25;

    // Synchronised bus pin samples
    typedef struct packed {
        logic scl;
        logic sda;
    } tsr_bus_t;

    // Drive of the data pin
    typedef struct packed {
        logic o;
        logic oe;
    } tsr_drive_t;
endpackage : tsr_pkg

// ==== rtl/tsr_sync.sv ====
// Two-stage synchroniser for the bus pins
`timescale 1ns/1ps
module tsr_sync #(
    parameter int W = 2
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    // First stage is read only by the second
    logic [W-1:0] meta_ff;

    // ----------------------------------------
    // Sampling chain, idle bus reads high
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_ff <= '1;
            dout <= '1;
        end
        else
        begin
            meta_ff <= din;
            dout <= meta_ff;
        end
    end
endmodule // tsr_sync

// ==== rtl/tsr_top.sv ====
// Two-wire slave with pointer-selected sensor registers
// What this block does
// (RL1) Pointer picks one of four registers
// (RL2) Pointer resets to temperature register
// (RL3) Pointer holds until new pointer byte
// (RL4) Temperature read only, others read-write
// (RL5) Master writes address, pointer, config byte
// (RL6) Second config byte replaces the first
// (RL7) Only first two data bytes used
// (RL8) Master writes limit as two bytes
// (RL9) Single limit byte lands in upper byte
// (RL10) Read with stored pointer: address, data
// (RL11) Master sets pointer then repeated start
// (RL12) Short read may leave data low
// (RL13) Nine clocks or high release; stop resets
// (RL14) Data low over 250 ms resets bus
// (RL15) Master keeps clock at least 6 Hz
// (RL16) Reset strobe restores all registers
// (RL17) Limit low seven bits read zero
// (RL18) Temperature frozen during a read
// (RL19) Any read clears interrupt-mode alarm
// (RL20) Every written byte acknowledged
`timescale 1ns/1ps
module tsr_top
    import tsr_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h48, // Arbitrary default bus address
    parameter bit TIMEOUT_EN = 1'b1, // Variant with bus timeout
    parameter int TIMEOUT_CNT = TIMEOUT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic scl_i,
    input wire logic sda_i,
    output tsr_pkg::tsr_drive_t sda_drv,
    input wire logic [15:0] temp_sample,
    input wire logic temp_valid,
    input wire logic alarm_event,
    output logic [7:0] config_q,
    output logic [15:0] hyst_limit_q,
    output logic [15:0] over_limit_q,
    output logic alarm_output
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001, // Waiting for start
        ST_ADDR = 5'b00010, // Shifting address byte
        ST_WRX = 5'b00100, // Receiving pointer or data
        ST_RDX = 5'b01000, // Sending data
        ST_ACK = 5'b10000 // Ninth clock slot
    } tsr_state_t;

    tsr_bus_t bus_s; // Synchronised pins
    tsr_bus_t prev_ff; // Previous sample for edges
    tsr_state_t state_ff, nxt_state;
    logic [3:0] bit_ff, nxt_bit; // Bit count in byte
    logic [7:0] sh_ff, nxt_sh; // Shift register
    logic [1:0] ptr_ff, nxt_ptr; // Register pointer
    logic [1:0] cnt_ff, nxt_cnt; // Bytes after address, saturating
    logic rd_ff, nxt_rd; // Transfer direction is read
    logic ack_rd_ff, nxt_ack_rd; // Ack slot driven by master, sampled here
    logic hi_ff, nxt_hi; // Next read byte is upper
    logic oe_ff, nxt_oe; // Data pin pulled low
    logic [7:0] cfg_ff, nxt_cfg;
    logic [15:0] hyst_ff, nxt_hyst;
    logic [15:0] over_ff, nxt_over;
    logic [15:0] temp_ff, nxt_temp;
    logic [15:0] rdw; // Word the pointer selects
    logic alarm_ff, nxt_alarm;
    logic [TIMEOUT_W-1:0] to_ff, nxt_to; // Data-low counter
    logic scl_rise, scl_fall, start_c, stop_c, tmo;

    tsr_sync #(.W(2)) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .din({scl_i, sda_i}),
        .dout(bus_s)
    );

    // ----------------------------------------
    // Bus events
    // ----------------------------------------
    assign scl_rise = bus_s.scl & ~prev_ff.scl;
    assign scl_fall = ~bus_s.scl & prev_ff.scl;
    assign start_c = bus_s.scl & prev_ff.scl & prev_ff.sda & ~bus_s.sda;
    assign stop_c = bus_s.scl & prev_ff.scl & ~prev_ff.sda & bus_s.sda;
    // (RL14) Timeout for stuck data
    assign tmo = TIMEOUT_EN && (to_ff >= TIMEOUT_W'(TIMEOUT_CNT));

    // (RL1) Pointer selects source
    always_comb
    begin
        case (ptr_ff)
            PTR_TEMP: rdw = temp_ff;
            PTR_CONFIG: rdw = {cfg_ff, cfg_ff};
            // (RL17) Limit low bits zero
            PTR_HYST: rdw = hyst_ff & LIMIT_MASK;
            default: rdw = over_ff & LIMIT_MASK;
        endcase
    end

    // ----------------------------------------
    // Protocol next state
    // ----------------------------------------
    always_comb
    begin
        nxt_state = state_ff;
        nxt_bit = bit_ff;
        nxt_sh = sh_ff;
        nxt_ptr = ptr_ff;
        nxt_cnt = cnt_ff;
        nxt_rd = rd_ff;
        nxt_ack_rd = ack_rd_ff;
        nxt_hi = hi_ff;
        nxt_oe = oe_ff;
        nxt_cfg = cfg_ff;
        nxt_hyst = hyst_ff;
        nxt_over = over_ff;
        nxt_alarm = alarm_ff;
        // Low counter clears whenever data is high
        nxt_to = bus_s.sda ? '0 : (tmo ? to_ff : to_ff + 1'b1);
        // Alarm event sets, read clears; set wins
        if (alarm_event)
            nxt_alarm = 1'b1;
        if (start_c)
        begin
            // Start or repeated start: fresh address byte
            nxt_state = ST_ADDR;
            nxt_bit = '0;
            nxt_oe = 1'b0;
        end
        else if (stop_c || tmo)
        begin
            // (RL13) Stop resets bus logic
            nxt_state = ST_IDLE;
            nxt_oe = 1'b0;
            nxt_to = '0;
        end
        else
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    nxt_oe = 1'b0;
                end
                ST_ADDR, ST_WRX:
                begin
                    if (scl_rise)
                    begin
                        nxt_sh = {sh_ff[6:0], bus_s.sda};
                        nxt_bit = bit_ff + 4'h1;
                    end
                    else if (scl_fall && bit_ff == 4'h8)
                    begin
                        nxt_state = ST_ACK;
                        nxt_ack_rd = 1'b0;
                        if (state_ff == ST_ADDR)
                        begin
                            nxt_oe = (sh_ff[7:1] == SLAVE_ADDR);
                            nxt_rd = sh_ff[0];
                            nxt_cnt = '0;
                            nxt_hi = 1'b1;
                            if (sh_ff[7:1] != SLAVE_ADDR)
                                nxt_state = ST_IDLE;
                        end
                        else
                        begin
                            // (RL20) Ack every written byte
                            nxt_oe = 1'b1;
                            if (cnt_ff != 2'h3)
                                nxt_cnt = cnt_ff + 2'h1;
                            if (cnt_ff == 2'h0)
                                // (RL3) Pointer latched here
                                nxt_ptr = sh_ff[1:0];
                            // (RL7) Bytes past two ignored
                            else if (cnt_ff <= 2'h2)
                            begin
                                // (RL4) Temperature not writable
                                case (ptr_ff)
                                    // (RL6) Later byte overrides
                                    PTR_CONFIG: nxt_cfg = sh_ff;
                                    // (RL9) First byte to upper
                                    PTR_HYST:
                                        if (cnt_ff == 2'h1)
                                            nxt_hyst = {sh_ff, 8'h00};
                                        else
                                            nxt_hyst = {hyst_ff[15:8], sh_ff} & LIMIT_MASK;
                                    PTR_OVER:
                                        if (cnt_ff == 2'h1)
                                            nxt_over = {sh_ff, 8'h00};
                                        else
                                            nxt_over = {over_ff[15:8], sh_ff} & LIMIT_MASK;
                                    default: ;
                                endcase
                            end
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_rise && ack_rd_ff && bus_s.sda)
                        // Master nack ends the read
                        nxt_state = ST_IDLE;
                    else if (scl_fall)
                    begin
                        nxt_bit = '0;
                        if (rd_ff)
                        begin
                            // (RL10) Return selected register
                            nxt_state = ST_RDX;
                            nxt_sh = hi_ff ? rdw[15:8] : rdw[7:0];
                            nxt_hi = ~hi_ff;
                            // (RL12) Drive first bit, may be low
                            nxt_oe = hi_ff ? ~rdw[15] : ~rdw[7];
                            // (RL19) Read clears the alarm
                            if (!alarm_event)
                                nxt_alarm = 1'b0;
                        end
                        else
                        begin
                            nxt_state = ST_WRX;
                            nxt_oe = 1'b0;
                        end
                    end
                end
                ST_RDX:
                begin
                    if (scl_rise)
                        nxt_bit = bit_ff + 4'h1;
                    else if (scl_fall)
                    begin
                        nxt_sh = {sh_ff[6:0], 1'b1};
                        if (bit_ff == 4'h8)
                        begin
                            // Release for master ack
                            nxt_state = ST_ACK;
                            nxt_ack_rd = 1'b1;
                            nxt_oe = 1'b0;
                        end
                        else
                            nxt_oe = ~sh_ff[6];
                    end
                end
                default: nxt_state = ST_IDLE;
            endcase
        end
        // Only interrupt mode holds alarm until read
        if (!cfg_ff[CFG_INT_MODE_BIT] && !alarm_event)
            nxt_alarm = 1'b0;
    end

    // (RL18) Temperature frozen while reading
    always_comb
    begin
        nxt_temp = temp_ff;
        if (temp_valid && !(rd_ff && ptr_ff == PTR_TEMP && state_ff != ST_IDLE))
            nxt_temp = temp_sample;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // (RL16) Reset restores power-up values
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prev_ff <= '1;
            state_ff <= ST_IDLE;
            bit_ff <= '0;
            sh_ff <= '0;
            // (RL2) Pointer reset value
            ptr_ff <= PTR_RESET;
            cnt_ff <= '0;
            rd_ff <= 1'b0;
            ack_rd_ff <= 1'b0;
            hi_ff <= 1'b1;
            oe_ff <= 1'b0;
            cfg_ff <= CONFIG_RESET;
            hyst_ff <= HYST_RESET;
            over_ff <= OVER_RESET;
            temp_ff <= '0;
            alarm_ff <= 1'b0;
            to_ff <= '0;
        end
        else
        begin
            prev_ff <= bus_s;
            state_ff <= nxt_state;
            bit_ff <= nxt_bit;
            sh_ff <= nxt_sh;
            ptr_ff <= nxt_ptr;
            cnt_ff <= nxt_cnt;
            rd_ff <= nxt_rd;
            ack_rd_ff <= nxt_ack_rd;
            hi_ff <= nxt_hi;
            oe_ff <= nxt_oe;
            cfg_ff <= nxt_cfg;
            hyst_ff <= nxt_hyst;
            over_ff <= nxt_over;
            temp_ff <= nxt_temp;
            alarm_ff <= nxt_alarm;
            to_ff <= nxt_to;
        end
    end

    // Outputs straight from flip-flops
    // One driver for the whole carrier; open drain never drives high
    assign sda_drv = '{o: 1'b0, oe: oe_ff};
    assign config_q = cfg_ff;
    assign hyst_limit_q = hyst_ff;
    assign over_limit_q = over_ff;
    assign alarm_output = alarm_ff;
endmodule // tsr_top

// ==== testbench/tsr_top_chk.sv ====
// Port checker for the two-wire register block
`timescale 1ns/1ps
module tsr_top_chk
    import tsr_pkg::*;
#(
    parameter int TIMEOUT_CNT = 200
) (
    input logic core_clk,
    input logic rstn,
    input logic scl_i,
    input logic sda_i,
    input tsr_pkg::tsr_drive_t sda_drv,
    input logic [15:0] temp_sample,
    input logic temp_valid,
    input logic alarm_event,
    input logic [7:0] config_q,
    input logic [15:0] hyst_limit_q,
    input logic [15:0] over_limit_q,
    input logic alarm_output
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    int low_cnt_ff; // Cycles the block holds data low
    int nxt_low_cnt;
    // Count only while our own drive holds the line
    always_comb
    begin
        nxt_low_cnt = (sda_drv.oe && !sda_i) ? low_cnt_ff + 1 : 0;
    end
    // Plain register of the count
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            low_cnt_ff <= 0;
        else
            low_cnt_ff <= nxt_low_cnt;
    end
    // --------------------
    // Properties
    // --------------------
    AST_LIMIT_LOW: assert property (((hyst_limit_q | over_limit_q) & ~LIMIT_MASK) == 16'h0000)
        else $error("limit low bits not zero");
    AST_RESET_VALS: assert property ($rose(rstn) |-> config_q == CONFIG_RESET && hyst_limit_q == HYST_RESET
        && over_limit_q == OVER_RESET && !sda_drv.oe)
        else $error("registers not at power-up values");
    AST_IDLE_HOLD: assert property ((scl_i && sda_i) [*8] |=> $stable({config_q, hyst_limit_q, over_limit_q}))
        else $error("register changed while bus idle");
    AST_ALARM_SET: assert property (alarm_event |=> alarm_output)
        else $error("alarm not raised after event");
    AST_ALARM_HOLD: assert property
        ((config_q[CFG_INT_MODE_BIT] && alarm_output && scl_i && sda_i) [*6] |=> alarm_output)
        else $error("interrupt alarm dropped without read");
    AST_OE_STEADY: assert property (scl_i && $past(scl_i) |-> $stable(sda_drv.oe))
        else $error("data drive changed while clock high");
    AST_OE_RISE: assert property ($rose(sda_drv.oe) |-> !scl_i ##1 !scl_i)
        else $error("data drive rose outside clock low");
    AST_TIMEOUT: assert property (low_cnt_ff <= TIMEOUT_CNT + 8)
        else $error("held data line outlived timeout");
    COV_ALARM: cover property ($fell(alarm_output));
    COV_HELD: cover property (low_cnt_ff == TIMEOUT_CNT / 2);
    COV_ACK: cover property ($rose(sda_drv.oe));
endmodule // tsr_top_chk

bind tsr_top tsr_top_chk #(.TIMEOUT_CNT(TIMEOUT_CNT)) tsr_top_chk_i (
    .core_clk(core_clk), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i), .sda_drv(sda_drv),
    .temp_sample(temp_sample), .temp_valid(temp_valid), .alarm_event(alarm_event), .config_q(config_q),
    .hyst_limit_q(hyst_limit_q), .over_limit_q(over_limit_q), .alarm_output(alarm_output)
);

// ==== testbench/tsr_mst_model.sv ====
// Bus master model: clock and open-drain data pull
`timescale 1ns/1ps
module tsr_mst_model (
    input logic core_clk,
    input logic sda_i,
    output logic scl,
    output logic sda_pull
);
    // Idle bus, clock parked high
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Quarter of the 160 ns bus period
    task automatic q();
        repeat (4) @(posedge core_clk);
    endtask
    task automatic start();
        sda_pull <= 1'b0;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic stop();
        sda_pull <= 1'b1;
        q();
        scl <= 1'b1;
        q();
        sda_pull <= 1'b0;
        q();
    endtask
    // Let go of data while the clock is low, so only the slave can hold it
    task automatic free_sda();
        sda_pull <= 1'b0;
        q();
    endtask
    task automatic bit_x(input logic b, output logic r);
        sda_pull <= ~b;
        q();
        scl <= 1'b1;
        q();
        r = sda_i;
        q();
        scl <= 1'b0;
        q();
    endtask
    task automatic wr(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = ~r;
    endtask
    // byte read, then ack or not
    task automatic rd(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(~mack, r);
    endtask
endmodule // tsr_mst_model

// ==== testbench/tsr_top_tb_top.sv ====
// Testbench of the two-wire register block
`timescale 1ns/1ps
module tsr_top_tb_top;
    import tsr_pkg::*;
    localparam logic [6:0] ADDR = 7'h48; // Arbitrary bus address
    localparam int TO_CNT = 400; // Short timeout keeps the run brief
    typedef struct packed {
        logic [1:0] p;
        logic [1:0] n;
        logic [23:0] d;
        logic [15:0] e;
    } tsr_row_t;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic scl;
    logic pull;
    logic sda_w;
    tsr_drive_t sda_drv;
    logic [15:0] temp_sample = 16'h0000;
    logic temp_valid = 1'b0;
    logic alarm_event = 1'b0;
    logic [7:0] config_q;
    logic [15:0] hyst_limit_q;
    logic [15:0] over_limit_q;
    logic alarm_output;
    logic [15:0] rd;
    logic [7:0] hi;
    logic ack;
    int fails = 0;
    int num_checks = 0;
    // Pointer, byte count, data bytes, expected two-byte read
    tsr_row_t rows [6] = '{
        '{PTR_CONFIG, 2'h1, 24'h060000, 16'h0606},
        '{PTR_CONFIG, 2'h2, 24'h020400, 16'h0404},
        '{PTR_HYST, 2'h2, 24'h12B400, 16'h1280},
        '{PTR_OVER, 2'h1, 24'h550000, 16'h5500},
        '{PTR_OVER, 2'h3, 24'h66FF11, 16'h6680},
        '{PTR_TEMP, 2'h2, 24'hAABB00, 16'h1900}
    };
    always #5 core_clk = ~core_clk;
    // Pulled-up data wire, low if either side pulls
    assign sda_w = ~pull & (~sda_drv.oe | sda_drv.o);
    tsr_top #(.SLAVE_ADDR(ADDR), .TIMEOUT_EN(1'b1), .TIMEOUT_CNT(TO_CNT)) tsr_top_i (
        .core_clk(core_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_w), .sda_drv(sda_drv),
        .temp_sample(temp_sample), .temp_valid(temp_valid), .alarm_event(alarm_event), .config_q(config_q),
        .hyst_limit_q(hyst_limit_q), .over_limit_q(over_limit_q), .alarm_output(alarm_output)
    );
    tsr_mst_model tsr_mst_model_i (.core_clk(core_clk), .sda_i(sda_w), .scl(scl), .sda_pull(pull));
    task automatic end_sim();
        if (fails == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Start, write address, pointer byte
    task automatic set_ptr(input logic [1:0] p);
        tsr_mst_model_i.start();
        tsr_mst_model_i.wr({ADDR, 1'b0}, ack);
        tsr_mst_model_i.wr({6'h00, p}, ack);
    endtask
    task automatic wr_reg(input logic [1:0] p, input logic [1:0] n, input logic [23:0] d);
        set_ptr(p);
        for (int i = 0; i < n; i++)
        begin
            tsr_mst_model_i.wr(d[23 - 8 * i -: 8], ack);
            chk("data ack", 16'h0001, {15'h0, ack});
        end
        tsr_mst_model_i.stop();
    endtask
    // Two-byte read, new pointer through repeat start if asked
    task automatic rd_reg(input logic setp, input logic [1:0] p, output logic [15:0] d);
        if (setp)
            set_ptr(p);
        tsr_mst_model_i.start();
        tsr_mst_model_i.wr({ADDR, 1'b1}, ack);
        tsr_mst_model_i.rd(1'b1, d[15:8]);
        tsr_mst_model_i.rd(1'b0, d[7:0]);
        tsr_mst_model_i.stop();
    endtask
    task automatic load_temp(input logic [15:0] v);
        temp_sample <= v;
        temp_valid <= 1'b1;
        @(posedge core_clk);
        temp_valid <= 1'b0;
        @(posedge core_clk);
    endtask
    // Upper byte acked, lower byte starts with a zero bit
    task automatic stuck();
        tsr_mst_model_i.start();
        tsr_mst_model_i.wr({ADDR, 1'b1}, ack);
        tsr_mst_model_i.rd(1'b1, hi);
        tsr_mst_model_i.free_sda();
        repeat (8) @(posedge core_clk);
        chk("held low", 16'h0001, {15'h0, sda_drv.oe});
        chk("held line", 16'h0000, {15'h0, sda_w});
    endtask
    // Watchdog well past the expected run length
    initial
    begin
        #500000;
        fails++;
        end_sim();
    end
    initial
    begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        load_temp(16'h1900);
        foreach (rows[i])
        begin
            wr_reg(rows[i].p, rows[i].n, rows[i].d);
            rd_reg(1'b0, 2'h0, rd);
            chk("row read", rows[i].e, rd);
        end
        rd_reg(1'b1, PTR_HYST, rd);
        chk("new pointer read", 16'h1280, rd);
        chk("over port", 16'h6680, over_limit_q);
        wr_reg(PTR_CONFIG, 2'h1, 24'h020000);
        alarm_event <= 1'b1;
        @(posedge core_clk);
        alarm_event <= 1'b0;
        repeat (30) @(posedge core_clk);
        chk("alarm held", 16'h0001, {15'h0, alarm_output});
        rd_reg(1'b0, 2'h0, rd);
        chk("alarm cleared", 16'h0000, {15'h0, alarm_output});
        set_ptr(PTR_TEMP);
        tsr_mst_model_i.start();
        tsr_mst_model_i.wr({ADDR, 1'b1}, ack);
        tsr_mst_model_i.rd(1'b1, rd[15:8]);
        load_temp(16'h7D80);
        tsr_mst_model_i.rd(1'b0, rd[7:0]);
        tsr_mst_model_i.stop();
        chk("frozen temperature", 16'h1900, rd);
        stuck();
        repeat (TO_CNT + 40) @(posedge core_clk);
        chk("timeout release", 16'h0000, {15'h0, sda_drv.oe});
        chk("timeout line", 16'h0001, {15'h0, sda_w});
        tsr_mst_model_i.stop();
        stuck();
        repeat (9) tsr_mst_model_i.bit_x(1'b1, ack);
        tsr_mst_model_i.stop();
        chk("clocked release", 16'h0000, {15'h0, sda_drv.oe});
        rd_reg(1'b1, PTR_OVER, rd);
        chk("read after recovery", 16'h6680, rd);
        rstn <= 1'b0;
        repeat (100) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk("config reset", 16'h0000, {8'h00, config_q});
        chk("hyst reset", 16'h4B00, hyst_limit_q);
        chk("over reset", 16'h5000, over_limit_q);
        load_temp(16'h0C80);
        rd_reg(1'b0, 2'h0, rd);
        chk("pointer after reset", 16'h0C80, rd);
        end_sim();
    end
endmodule // tsr_top_tb_top
